// ---- include/io_space_pkg.sv ----
// Constants, op codes and register layout for the I/O register space
// Operation
// - Single-bit set and clear reach only I/O addresses 0x00 to 0x1F; higher ones are refused.
// - Skip-if-set and skip-if-clear test one bit of a register in the same low range.
// - A flag at 0x15 to 0x17, 0x1B or 0x1C clears when a one is written to it and holds when a zero is written; SPI status flags clear on spi_status_clear.
// - Single-bit set or clear changes only the addressed bit, never other flags alongside.
// - I/O input and output ops use I/O addresses 0x00 to 0x3F only.
// - Data-space load and store see each register at its I/O address plus 0x20.
// - Data addresses 0x60 to 0xFF are reached by load and store only, never by I/O ops.
`default_nettype none
package io_space_pkg;
    typedef enum logic [3:0] {
        op_idle                 = 4'h0,
        io_input_op             = 4'h1,
        io_output_op            = 4'h2,
        single_bit_set_op       = 4'h3,
        single_bit_clear_op     = 4'h4,
        skip_if_io_bit_set_op   = 4'h5,
        skip_if_io_bit_clear_op = 4'h6,
        data_space_load_op      = 4'h7,
        data_space_store_op     = 4'h8,
        direct_load_op          = 4'h9,
        direct_store_op         = 4'hA
    } io_op_t;

    localparam logic [7:0] BIT_LIMIT   = 8'h1F;
    localparam logic [7:0] IO_LIMIT    = 8'h3F;
    localparam logic [7:0] DATA_OFFSET = 8'h20;
    localparam logic [7:0] EXT_LOW     = 8'h60;
    localparam logic [7:0] RESET_VALUE = 8'h00;

    localparam logic [5:0] OFS_PORT_B_PIN     = 6'h03;
    localparam logic [5:0] OFS_PORT_B_DIR     = 6'h04;
    localparam logic [5:0] OFS_PORT_B_OUT     = 6'h05;
    localparam logic [5:0] OFS_PORT_C_PIN     = 6'h06;
    localparam logic [5:0] OFS_PORT_C_DIR     = 6'h07;
    localparam logic [5:0] OFS_PORT_C_OUT     = 6'h08;
    localparam logic [5:0] OFS_PORT_D_PIN     = 6'h09;
    localparam logic [5:0] OFS_PORT_D_DIR     = 6'h0A;
    localparam logic [5:0] OFS_PORT_D_OUT     = 6'h0B;
    localparam logic [5:0] OFS_TIMER0_FLAGS   = 6'h15;
    localparam logic [5:0] OFS_TIMER1_FLAGS   = 6'h16;
    localparam logic [5:0] OFS_TIMER2_FLAGS   = 6'h17;
    localparam logic [5:0] OFS_PIN_CHG_FLAGS  = 6'h1B;
    localparam logic [5:0] OFS_EXT_FLAGS      = 6'h1C;
    localparam logic [5:0] OFS_EXT_ENABLES    = 6'h1D;
    localparam logic [5:0] OFS_SCRATCH0       = 6'h1E;
    localparam logic [5:0] OFS_NV_CONTROL     = 6'h1F;
    localparam logic [5:0] OFS_NV_DATA        = 6'h20;
    localparam logic [5:0] OFS_NV_ADDR_LOW    = 6'h21;
    localparam logic [5:0] OFS_NV_ADDR_HIGH   = 6'h22;
    localparam logic [5:0] OFS_PRESCALER_SYNC = 6'h23;
    localparam logic [5:0] OFS_TIMER0_CTRL_A  = 6'h24;
    localparam logic [5:0] OFS_TIMER0_CTRL_B  = 6'h25;
    localparam logic [5:0] OFS_TIMER0_COUNT   = 6'h26;
    localparam logic [5:0] OFS_TIMER0_MATCH_A = 6'h27;
    localparam logic [5:0] OFS_TIMER0_MATCH_B = 6'h28;
    localparam logic [5:0] OFS_SCRATCH1       = 6'h2A;
    localparam logic [5:0] OFS_SCRATCH2       = 6'h2B;
    localparam logic [5:0] OFS_SPI_CONTROL    = 6'h2C;
    localparam logic [5:0] OFS_SPI_STATE      = 6'h2D;

    localparam logic [7:0] PORT_C_MASK     = 8'h7F;
    localparam logic [7:0] TIMER_FLAG_MASK = 8'h07;
    localparam logic [7:0] TIMER1_FLAG_MASK = 8'h27;
    localparam logic [7:0] EXT_LINE_MASK   = 8'h03;
    localparam logic [7:0] NV_CONTROL_MASK = 8'h3F;
    localparam logic [7:0] PRESCALER_MASK  = 8'h83;
    localparam logic [7:0] CTRL_A_MASK     = 8'hF3;
    localparam logic [7:0] CTRL_B_MASK     = 8'h0F;
    localparam logic [7:0] FORCE_MASK      = 8'hC0;
    localparam logic [7:0] SPI_RW_MASK     = 8'h01;
    localparam logic [7:0] SPI_STATUS_MASK = 8'hC0;
endpackage
`default_nettype wire

// ---- include/io_access_if.sv ----
// Decoded access passed between the decoder's own modules
`timescale 1ns/1ps
`default_nettype none
interface io_access_if;
    import io_space_pkg::*;
    io_op_t     op;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
    logic       hit;
    logic       ext_hit;
    logic [5:0] idx;
    logic       wr;
    logic       bit_op;
    logic       skip_op;
    logic [7:0] wmask;
    logic [7:0] wbits;
    modport map (input op, addr, output hit, ext_hit, idx, wr, bit_op, skip_op);
    modport bits (input op, bit_sel, wdata, bit_op, output wmask, wbits);
    modport top (output op, addr, bit_sel, wdata,
                 input hit, ext_hit, idx, wr, bit_op, skip_op, wmask, wbits);
endinterface
`default_nettype wire

// ---- hw/io_address_map.sv ----
// Address decoder from op and address to register index
`timescale 1ns/1ps
`default_nettype none
module io_address_map
    import io_space_pkg::*;
(
    io_access_if.map acc
);
    wire is_io    = acc.op == io_input_op || acc.op == io_output_op;
    wire is_bit   = acc.op == single_bit_set_op || acc.op == single_bit_clear_op;
    wire is_skip  = acc.op == skip_if_io_bit_set_op || acc.op == skip_if_io_bit_clear_op;
    wire is_store = acc.op == data_space_store_op || acc.op == direct_store_op;
    wire is_data  = is_store || acc.op == data_space_load_op || acc.op == direct_load_op;
    wire io_ok    = acc.addr <= IO_LIMIT;
    wire low_ok   = acc.addr <= BIT_LIMIT;
    wire data_ok  = acc.addr >= DATA_OFFSET && acc.addr < EXT_LOW;
    wire [7:0] data_idx = acc.addr - DATA_OFFSET;

    assign acc.bit_op  = is_bit && low_ok;
    assign acc.skip_op = is_skip && low_ok;
    // Extended range answers only data-space ops
    assign acc.ext_hit = is_data && acc.addr >= EXT_LOW;
    assign acc.hit     = (is_io && io_ok) || acc.bit_op || acc.skip_op
                       || (is_data && data_ok);
    assign acc.idx     = is_data ? data_idx[5:0] : acc.addr[5:0];
    assign acc.wr      = acc.hit && (acc.op == io_output_op || acc.bit_op || is_store);
endmodule // io_address_map
`default_nettype wire

// ---- hw/io_bit_unit.sv ----
// Byte-lane mask and write bits for byte and single-bit writes
`timescale 1ns/1ps
`default_nettype none
module io_bit_unit
    import io_space_pkg::*;
(
    io_access_if.bits acc
);
    wire [7:0] one_hot = 8'h01 << acc.bit_sel;
    // A bit op touches one lane only, so neighbouring flags are safe
    assign acc.wmask = acc.bit_op ? one_hot : 8'hFF;
    assign acc.wbits = !acc.bit_op ? acc.wdata :
                       (acc.op == single_bit_set_op) ? one_hot : 8'h00;
endmodule // io_bit_unit
`default_nettype wire

// ---- hw/io_register_space_decoder.sv ----
// I/O register space with bit access, flag clearing and address mapping
`timescale 1ns/1ps
`default_nettype none
module io_register_space_decoder
    import io_space_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire io_op_t       op,
    input  wire logic [7:0]   addr,
    input  wire logic [2:0]   bit_sel,
    input  wire logic [7:0]   wdata,
    output logic              rsp_valid,
    output logic [7:0]        rdata,
    output logic              skip,
    output logic              refused,
    input  wire logic [7:0]   port_b_pins,
    input  wire logic [6:0]   port_c_pins,
    input  wire logic [7:0]   port_d_pins,
    input  wire logic [2:0]   timer0_events,
    input  wire logic [3:0]   timer1_events,
    input  wire logic [2:0]   timer2_events,
    input  wire logic [2:0]   pin_change_events,
    input  wire logic [1:0]   external_line_events,
    input  wire logic [1:0]   spi_status_events,
    input  wire logic         spi_status_clear,
    output logic [1:0]        timer0_force_pulse,
    output logic [63:0][7:0]  io_image
);
    io_access_if acc ();

    assign acc.op      = op;
    assign acc.addr    = addr;
    assign acc.bit_sel = bit_sel;
    assign acc.wdata   = wdata;

    io_address_map u_map (
        .acc (acc.map)
    );

    io_bit_unit u_bits (
        .acc (acc.bits)
    );

    function automatic logic [7:0] rw_mask(input logic [5:0] i);
        case (i)
            OFS_PORT_B_DIR, OFS_PORT_B_OUT, OFS_PORT_D_DIR, OFS_PORT_D_OUT,
            OFS_SCRATCH0, OFS_NV_DATA, OFS_NV_ADDR_LOW, OFS_NV_ADDR_HIGH,
            OFS_TIMER0_COUNT, OFS_TIMER0_MATCH_A, OFS_TIMER0_MATCH_B,
            OFS_SCRATCH1, OFS_SCRATCH2, OFS_SPI_CONTROL: rw_mask = 8'hFF;
            OFS_PORT_C_DIR, OFS_PORT_C_OUT: rw_mask = PORT_C_MASK;
            OFS_EXT_ENABLES:     rw_mask = EXT_LINE_MASK;
            OFS_NV_CONTROL:      rw_mask = NV_CONTROL_MASK;
            OFS_PRESCALER_SYNC:  rw_mask = PRESCALER_MASK;
            OFS_TIMER0_CTRL_A:   rw_mask = CTRL_A_MASK;
            OFS_TIMER0_CTRL_B:   rw_mask = CTRL_B_MASK;
            OFS_SPI_STATE:       rw_mask = SPI_RW_MASK;
            default:             rw_mask = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] w1c_mask(input logic [5:0] i);
        case (i)
            OFS_TIMER0_FLAGS, OFS_TIMER2_FLAGS, OFS_PIN_CHG_FLAGS:
                              w1c_mask = TIMER_FLAG_MASK;
            OFS_TIMER1_FLAGS: w1c_mask = TIMER1_FLAG_MASK;
            OFS_EXT_FLAGS:    w1c_mask = EXT_LINE_MASK;
            default:          w1c_mask = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] stat_mask(input logic [5:0] i);
        stat_mask = (i == OFS_SPI_STATE) ? SPI_STATUS_MASK : 8'h00;
    endfunction

    logic [7:0] regs     [64];
    logic [7:0] next_reg [64];
    logic [7:0] hw_set   [64];
    logic [7:0] read_val;

    always_comb begin
        for (int k = 0; k < 64; k++) begin
            hw_set[k] = 8'h00;
        end
        hw_set[OFS_TIMER0_FLAGS]  = {5'h00, timer0_events};
        hw_set[OFS_TIMER1_FLAGS]  = {2'h0, timer1_events[3], 2'h0, timer1_events[2:0]};
        hw_set[OFS_TIMER2_FLAGS]  = {5'h00, timer2_events};
        hw_set[OFS_PIN_CHG_FLAGS] = {5'h00, pin_change_events};
        hw_set[OFS_EXT_FLAGS]     = {6'h00, external_line_events};
        hw_set[OFS_SPI_STATE]     = {spi_status_events, 6'h00};
    end

    genvar g;
    generate
        for (g = 0; g < 64; g++) begin : g_reg
            localparam logic [5:0] IDX = 6'(g);
            wire [7:0] we       = (acc.wr && acc.idx == IDX) ? acc.wmask : 8'h00;
            wire [7:0] rw_part  = ((regs[g] & ~we) | (acc.wbits & we)) & rw_mask(IDX);
            wire [7:0] fl_mask  = w1c_mask(IDX) | stat_mask(IDX);
            // Write one clears, write zero leaves the flag alone
            wire [7:0] fl_clr   = (we & acc.wbits & w1c_mask(IDX))
                                | ({8{spi_status_clear}} & stat_mask(IDX));
            // An event in the clearing cycle still lands
            wire [7:0] fl_part  = ((regs[g] & ~fl_clr) | hw_set[g]) & fl_mask;
            assign next_reg[g] = rw_part | fl_part;
            assign io_image[g] = regs[g];

            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    regs[g] <= RESET_VALUE;
                end else begin
                    regs[g] <= next_reg[g];
                end
            end
        end
    endgenerate

    // Pin levels are live inputs, not stored
    always_comb begin
        case (acc.idx)
            OFS_PORT_B_PIN: read_val = port_b_pins;
            OFS_PORT_C_PIN: read_val = {1'b0, port_c_pins};
            OFS_PORT_D_PIN: read_val = port_d_pins;
            default: read_val = regs[acc.idx] &
                     (rw_mask(acc.idx) | w1c_mask(acc.idx) | stat_mask(acc.idx));
        endcase
    end

    wire       is_active = op != op_idle;
    wire       is_read   = acc.hit && !acc.wr && !acc.skip_op;
    wire       bit_val   = read_val[bit_sel];
    wire       next_skip = acc.skip_op &&
                           ((op == skip_if_io_bit_set_op) ? bit_val : !bit_val);
    wire [7:0] force_hit = (acc.wr && acc.idx == OFS_TIMER0_CTRL_B)
                           ? (acc.wmask & acc.wbits & FORCE_MASK) : 8'h00;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rsp_valid          <= 1'b0;
            rdata              <= 8'h00;
            skip               <= 1'b0;
            refused            <= 1'b0;
            timer0_force_pulse <= 2'b00;
        end else begin
            rsp_valid          <= is_active;
            rdata              <= is_read ? read_val : 8'h00;
            skip               <= next_skip;
            refused            <= is_active && !acc.hit && !acc.ext_hit;
            timer0_force_pulse <= force_hit[7:6];
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic [7:0] past_val;
    logic [5:0] past_idx;
    logic [7:0] past_mask;
    logic [7:0] past_set;
    always_ff @(posedge clk) begin
        past_idx  <= acc.idx;
        past_val  <= regs[acc.idx];
        past_mask <= acc.wmask;
        past_set  <= hw_set[acc.idx];
    end

    sequence bit_op_high_s;
        (op == single_bit_set_op || op == single_bit_clear_op) && addr > BIT_LIMIT;
    endsequence
    sequence flag_one_s;
        op == io_output_op && addr == 8'(OFS_TIMER0_FLAGS) && wdata[0]
        && !timer0_events[0];
    endsequence
    sequence flag_zero_s;
        op == io_output_op && addr == 8'(OFS_TIMER0_FLAGS) && !wdata[0]
        && !timer0_events[0];
    endsequence
    sequence bit_write_s;
        acc.bit_op;
    endsequence

    bit_range_a: assert property (bit_op_high_s |=> refused && rsp_valid)
        else $error("bit op above low range not refused");
    skip_value_a: assert property (
        op == skip_if_io_bit_set_op && addr <= BIT_LIMIT && read_val[bit_sel]
        |=> skip)
        else $error("skip missed on set bit");
    flag_clear_a: assert property (flag_one_s |=> regs[OFS_TIMER0_FLAGS][0] == 1'b0)
        else $error("flag not cleared by one");
    flag_hold_a: assert property (flag_zero_s
        |=> regs[OFS_TIMER0_FLAGS][0] == $past(regs[OFS_TIMER0_FLAGS][0]))
        else $error("flag changed by zero write");
    bit_only_a: assert property (bit_write_s
        |=> ((regs[past_idx] ^ past_val) & ~past_mask & ~past_set) == 8'h00)
        else $error("bit op touched other bits");
    io_range_a: assert property (
        (op == io_input_op || op == io_output_op) && addr > IO_LIMIT
        |=> refused && rsp_valid && rdata == 8'h00)
        else $error("io op above range not refused");
    data_map_a: assert property (
        op == data_space_load_op && addr >= DATA_OFFSET && addr < EXT_LOW
        |-> acc.hit && acc.idx == 6'(addr - DATA_OFFSET))
        else $error("data address not shifted by offset");
    // No registers live there, yet data ops must not be refused
    ext_only_a: assert property (
        (op == data_space_load_op || op == direct_load_op || op == data_space_store_op
         || op == direct_store_op) && addr >= EXT_LOW |=> !refused && rdata == 8'h00)
        else $error("extended access mishandled");
    reserved_zero_a: assert property (
        op == io_input_op && addr == 8'h00 |=> rdata == 8'h00 && rsp_valid)
        else $error("reserved address read not zero");
    bit_set_lands_a: assert property (
        op == single_bit_set_op && addr == 8'(OFS_SCRATCH0)
        |=> regs[OFS_SCRATCH0][$past(bit_sel)])
        else $error("single-bit set did not land");
    bit_clear_lands_a: assert property (
        op == single_bit_clear_op && addr == 8'(OFS_SCRATCH0)
        |=> !regs[OFS_SCRATCH0][$past(bit_sel)])
        else $error("single-bit clear did not land");
    skip_clear_a: assert property (
        op == skip_if_io_bit_clear_op && addr <= BIT_LIMIT && !read_val[bit_sel]
        |=> skip && !refused)
        else $error("skip missed on clear bit");
    skip_high_a: assert property (
        (op == skip_if_io_bit_set_op || op == skip_if_io_bit_clear_op) && addr > BIT_LIMIT
        |=> refused && !skip)
        else $error("skip op above low range not refused");
    // Set wins, so an event in the clearing cycle is never lost
    flag_set_wins_a: assert property (timer0_events[0] |=> regs[OFS_TIMER0_FLAGS][0])
        else $error("flag event lost");
    io_write_a: assert property (
        op == io_output_op && addr == 8'(OFS_PORT_B_OUT)
        |=> regs[OFS_PORT_B_OUT] == $past(wdata))
        else $error("io write did not land");
    store_map_a: assert property (
        (op == data_space_store_op || op == direct_store_op)
        && addr == 8'(OFS_SCRATCH1) + DATA_OFFSET
        |=> regs[OFS_SCRATCH1] == $past(wdata))
        else $error("store not placed at offset");
    low_store_a: assert property (
        (op == data_space_store_op || op == direct_store_op) && addr < DATA_OFFSET
        |=> refused && rsp_valid)
        else $error("store below offset not refused");
endmodule // io_register_space_decoder
`default_nettype wire

// ---- sim/core_model.sv ----
// Processor core model issuing I/O and load/store operations
`timescale 1ns/1ps
`default_nettype none
module core_model
    import io_space_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rsp_valid,
    input  wire logic [7:0] rdata,
    input  wire logic       skip,
    input  wire logic       refused,
    output var io_op_t      op,
    output logic [7:0]      addr,
    output logic [2:0]      bit_sel,
    output logic [7:0]      wdata
);
    logic       got_valid;
    logic [7:0] got_rdata;
    logic       got_skip;
    logic       got_refused;

    initial begin
        op = op_idle;
        addr = 8'h00;
        bit_sel = 3'h0;
        wdata = 8'h00;
    end

    // Entered just after a falling edge; the op is left up so calls run back to back
    task automatic access(input io_op_t o, input logic [7:0] a, input logic [2:0] b,
                          input logic [7:0] d);
        op = o;
        addr = a;
        bit_sel = b;
        wdata = d;
        @(negedge clk);
        got_valid = rsp_valid;
        got_rdata = rdata;
        got_skip = skip;
        got_refused = refused;
    endtask
endmodule // core_model
`default_nettype wire

// ---- sim/io_register_space_decoder_bench.sv ----
// Self-checking bench for the I/O register space decoder
`timescale 1ns/1ps
`default_nettype none
module io_register_space_decoder_bench import io_space_pkg::*;;
    typedef struct {
        io_op_t     op;
        logic [7:0] a;
        logic [2:0] b;
        logic [7:0] d;
        logic [7:0] rd;
        logic       sk;
        logic       rf;
    } row_t;

    logic            clk;
    logic            sys_rst;
    io_op_t          op;
    logic [7:0]      addr;
    logic [2:0]      bit_sel;
    logic [7:0]      wdata;
    logic            rsp_valid;
    logic [7:0]      rdata;
    logic            skip;
    logic            refused;
    logic [7:0]      port_b_pins = 8'hA5;
    logic [6:0]      port_c_pins = 7'h5A;
    logic [7:0]      port_d_pins = 8'h3C;
    logic [2:0]      timer0_events = 3'h0;
    logic [3:0]      timer1_events = 4'h0;
    logic [2:0]      timer2_events = 3'h0;
    logic [2:0]      pin_change_events = 3'h0;
    logic [1:0]      external_line_events = 2'h0;
    logic [1:0]      spi_status_events = 2'h0;
    logic            spi_status_clear = 1'h0;
    logic [1:0]      timer0_force_pulse;
    logic [63:0][7:0] io_image;
    int              n_errors = 0;
    int              comparisons = 0;
    logic [7:0]      flag_addr [0:5] = '{8'h15, 8'h16, 8'h17, 8'h1B, 8'h1C, 8'h2D};
    logic [7:0]      flag_mask [0:5] = '{8'h07, 8'h27, 8'h07, 8'h07, 8'h03, 8'hC0};

    // Pins read A5, 5A, 3C at 0x03, 0x06, 0x09; earlier rows leave state for later ones
    row_t rows [0:28] = '{
        '{io_output_op, 8'h05, 3'h0, 8'h96, 8'h00, 1'h0, 1'h0},
        '{io_input_op, 8'h05, 3'h0, 8'h00, 8'h96, 1'h0, 1'h0},
        '{data_space_load_op, 8'h25, 3'h0, 8'h00, 8'h96, 1'h0, 1'h0},
        '{direct_store_op, 8'h4A, 3'h0, 8'h3C, 8'h00, 1'h0, 1'h0},
        '{io_input_op, 8'h2A, 3'h0, 8'h00, 8'h3C, 1'h0, 1'h0},
        '{single_bit_set_op, 8'h1E, 3'h7, 8'h00, 8'h00, 1'h0, 1'h0},
        '{single_bit_set_op, 8'h1E, 3'h0, 8'h00, 8'h00, 1'h0, 1'h0},
        '{single_bit_clear_op, 8'h1E, 3'h7, 8'h00, 8'h00, 1'h0, 1'h0},
        '{io_input_op, 8'h1E, 3'h0, 8'h00, 8'h01, 1'h0, 1'h0},
        '{single_bit_set_op, 8'h1F, 3'h5, 8'h00, 8'h00, 1'h0, 1'h0},
        '{io_input_op, 8'h1F, 3'h0, 8'h00, 8'h20, 1'h0, 1'h0},
        '{skip_if_io_bit_set_op, 8'h1E, 3'h0, 8'h00, 8'h00, 1'h1, 1'h0},
        '{skip_if_io_bit_set_op, 8'h1E, 3'h1, 8'h00, 8'h00, 1'h0, 1'h0},
        '{skip_if_io_bit_clear_op, 8'h1E, 3'h1, 8'h00, 8'h00, 1'h1, 1'h0},
        '{skip_if_io_bit_clear_op, 8'h03, 3'h0, 8'h00, 8'h00, 1'h0, 1'h0},
        '{single_bit_set_op, 8'h20, 3'h0, 8'h00, 8'h00, 1'h0, 1'h1},
        '{skip_if_io_bit_clear_op, 8'h20, 3'h0, 8'h00, 8'h00, 1'h0, 1'h1},
        '{io_input_op, 8'h40, 3'h0, 8'h00, 8'h00, 1'h0, 1'h1},
        '{io_input_op, 8'h3F, 3'h0, 8'h00, 8'h00, 1'h0, 1'h0},
        '{io_input_op, 8'h60, 3'h0, 8'h00, 8'h00, 1'h0, 1'h1},
        '{direct_load_op, 8'h60, 3'h0, 8'h00, 8'h00, 1'h0, 1'h0},
        '{direct_load_op, 8'h1F, 3'h0, 8'h00, 8'h00, 1'h0, 1'h1},
        '{io_input_op, 8'h06, 3'h0, 8'h00, 8'h5A, 1'h0, 1'h0},
        '{data_space_load_op, 8'h29, 3'h0, 8'h00, 8'h3C, 1'h0, 1'h0},
        '{data_space_store_op, 8'h4B, 3'h0, 8'h5A, 8'h00, 1'h0, 1'h0},
        '{io_input_op, 8'h2B, 3'h0, 8'h00, 8'h5A, 1'h0, 1'h0},
        '{data_space_store_op, 8'h10, 3'h0, 8'hFF, 8'h00, 1'h0, 1'h1},
        '{direct_store_op, 8'h80, 3'h0, 8'h00, 8'h00, 1'h0, 1'h0},
        '{io_input_op, 8'h02, 3'h0, 8'h00, 8'h00, 1'h0, 1'h0}
    };

    core_model i_core (.clk(clk), .rsp_valid(rsp_valid), .rdata(rdata), .skip(skip),
        .refused(refused), .op(op), .addr(addr), .bit_sel(bit_sel), .wdata(wdata));

    io_register_space_decoder i_dut (.clk(clk), .sys_rst(sys_rst), .op(op), .addr(addr),
        .bit_sel(bit_sel), .wdata(wdata), .rsp_valid(rsp_valid), .rdata(rdata),
        .skip(skip), .refused(refused), .port_b_pins(port_b_pins),
        .port_c_pins(port_c_pins), .port_d_pins(port_d_pins),
        .timer0_events(timer0_events), .timer1_events(timer1_events),
        .timer2_events(timer2_events), .pin_change_events(pin_change_events),
        .external_line_events(external_line_events), .spi_status_events(spi_status_events),
        .spi_status_clear(spi_status_clear), .timer0_force_pulse(timer0_force_pulse),
        .io_image(io_image));

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check1(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic run(input io_op_t o, input logic [7:0] a, input logic [2:0] b,
                       input logic [7:0] d, input logic [7:0] rd, input logic sk,
                       input logic rf);
        i_core.access(o, a, b, d);
        check1("rsp_valid", 1'h1, i_core.got_valid);
        check8("rdata", rd, i_core.got_rdata);
        check1("skip", sk, i_core.got_skip);
        check1("refused", rf, i_core.got_refused);
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // About 130 cycles are needed; a normal run ends well short of the 3000-cycle limit
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        end_sim();
    end

    initial begin
        sys_rst = 1'h1;
        repeat (8) @(negedge clk);
        sys_rst = 1'h0;
        for (int i = 0; i < 64; i++) begin
            run(io_input_op, 8'(i), 3'h0, 8'h00, (i == 3) ? 8'hA5 : (i == 6) ? 8'h5A :
                (i == 9) ? 8'h3C : 8'h00, 1'h0, 1'h0);
        end
        foreach (rows[k]) begin
            run(rows[k].op, rows[k].a, rows[k].b, rows[k].d, rows[k].rd, rows[k].sk,
                rows[k].rf);
        end
        check8("image port b", 8'h96, io_image[5]);
        // One cycle of every event source, then each flag register read back
        timer0_events = 3'h7;
        timer1_events = 4'hF;
        timer2_events = 3'h7;
        pin_change_events = 3'h7;
        external_line_events = 2'h3;
        spi_status_events = 2'h3;
        @(negedge clk);
        timer0_events = 3'h0;
        timer1_events = 4'h0;
        timer2_events = 3'h0;
        pin_change_events = 3'h0;
        external_line_events = 2'h0;
        spi_status_events = 2'h0;
        for (int j = 0; j < 6; j++) begin
            run(io_input_op, flag_addr[j], 3'h0, 8'h00, flag_mask[j], 1'h0, 1'h0);
        end
        run(single_bit_set_op, 8'h16, 3'h1, 8'h00, 8'h00, 1'h0, 1'h0);
        run(single_bit_clear_op, 8'h16, 3'h0, 8'h00, 8'h00, 1'h0, 1'h0);
        run(io_output_op, 8'h16, 3'h0, 8'h00, 8'h00, 1'h0, 1'h0);
        run(io_input_op, 8'h16, 3'h0, 8'h00, 8'h25, 1'h0, 1'h0);
        run(io_output_op, 8'h16, 3'h0, 8'h04, 8'h00, 1'h0, 1'h0);
        run(io_input_op, 8'h16, 3'h0, 8'h00, 8'h21, 1'h0, 1'h0);
        // Zero bits leave flags alone; an event in the clearing cycle wins
        run(io_output_op, 8'h15, 3'h0, 8'h02, 8'h00, 1'h0, 1'h0);
        run(io_input_op, 8'h15, 3'h0, 8'h00, 8'h05, 1'h0, 1'h0);
        timer0_events = 3'h1;
        run(io_output_op, 8'h15, 3'h0, 8'h05, 8'h00, 1'h0, 1'h0);
        timer0_events = 3'h0;
        run(io_input_op, 8'h15, 3'h0, 8'h00, 8'h01, 1'h0, 1'h0);
        run(io_output_op, 8'h15, 3'h0, 8'h01, 8'h00, 1'h0, 1'h0);
        run(io_input_op, 8'h15, 3'h0, 8'h00, 8'h00, 1'h0, 1'h0);
        spi_status_clear = 1'h1;
        @(negedge clk);
        spi_status_clear = 1'h0;
        run(io_input_op, 8'h2D, 3'h0, 8'h00, 8'h00, 1'h0, 1'h0);
        // Strobe bits pulse once and never read back
        run(io_output_op, 8'h25, 3'h0, 8'hC3, 8'h00, 1'h0, 1'h0);
        check8("force pulse", 8'h03, {6'h00, timer0_force_pulse});
        run(io_input_op, 8'h25, 3'h0, 8'h00, 8'h03, 1'h0, 1'h0);
        check8("force pulse", 8'h00, {6'h00, timer0_force_pulse});
        // Second reset in mid-run wipes stored registers
        sys_rst = 1'h1;
        @(negedge clk);
        check1("rsp_valid in reset", 1'h0, rsp_valid);
        sys_rst = 1'h0;
        run(io_input_op, 8'h05, 3'h0, 8'h00, 8'h00, 1'h0, 1'h0);
        end_sim();
    end
endmodule // io_register_space_decoder_bench
`default_nettype wire
